// ---- rtl/pcc_consts.vh ----
// pcc_consts.vh: offsets, field positions, reset values of the primary config/control bank
// assumes inclusion by pcc_regs.v only
`ifndef PCC_CONSTS_VH
`define PCC_CONSTS_VH
`define PCC_OFS_CFG 7'h04
`define PCC_OFS_CTRL 7'h06
`define PCC_RST_CFG 16'h00C4
`define PCC_RST_CTRL 16'h0001
`define PCC_BIT_PAR 0
`define PCC_BIT_DISC 1
`define PCC_BIT_RXCHK 2
`define PCC_BIT_AMODE 6
`define PCC_BIT_BMODE 7
`define PCC_BIT_BLANK 2
`define PCC_BIT_CLRREQ 5
`endif

// ---- rtl/pcc_regs.v ----
// pcc_regs.v: primary configuration and run-time control registers
// assumes a word-level access port from the serial front end on the same clock
`timescale 1ns/100ps
`include "pcc_consts.vh"
module pcc_regs (
   input wire clk,
   input wire rst_n,
   input wire msgValid,
   input wire msgParityOk,
   input wire msgWrite,
   input wire [6:0] msgAddr,
   input wire [15:0] msgWdata,
   output reg [15:0] rdData,
   output wire rxCheckEnable,
   output wire blankingTimeSelect,
   output wire stickyClear,
   input wire faultAEvent,
   input wire faultBEvent,
   input wire classACondition,
   input wire classBCondition,
   output wire faultPinA_n,
   output wire faultPinB_n
);
   // ----------------------------------------------------------------
   // reset words
   // ----------------------------------------------------------------
   localparam [15:0] RST_CFG = `PCC_RST_CFG;
   localparam [15:0] RST_CTRL = `PCC_RST_CTRL;

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   reg bModeQ_q;
   reg bModeQ_d;
   reg aModeQ_q;
   reg aModeQ_d;
   reg rxChk_q;
   reg rxChk_d;
   reg blank_q;
   reg blank_d;
   reg clrReq_q;
   reg clrReq_d;
   reg discarded_q;
   reg discarded_d;
   reg faultA_q;
   reg faultA_d;
   reg faultB_q;
   reg faultB_d;
   reg [15:0] rdData_d;
   wire msgOk;
   wire hitCfg;
   wire hitCtrl;
   wire cfgWrite;
   wire ctrlWrite;
   wire releaseA;
   wire releaseB;
   wire [15:0] cfgBody;
   wire [15:0] ctrlBody;
   wire [15:0] cfgWord;
   wire [15:0] ctrlWord;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function [15:0] withParity;
      input [15:0] w;
      begin
         withParity = {w[15:1], ~(^w[15:1])};
      end
   endfunction

   function addrHit;
      input [6:0] addr;
      input [6:0] ofs;
      begin
         addrHit = (addr == ofs);
      end
   endfunction

   function takeWrite;
      input valid;
      input ok;
      input wr;
      input hit;
      begin
         takeWrite = valid & ok & wr & hit;
      end
   endfunction

   function mayRelease;
      input req;
      input mode;
      input cond;
      begin
         mayRelease = req & (~mode | ~cond);
      end
   endfunction

   // ----------------------------------------------------------------
   // message acceptance
   // ----------------------------------------------------------------
   assign msgOk = msgParityOk | ~rxChk_q;
   assign hitCfg = addrHit(msgAddr, `PCC_OFS_CFG);
   assign hitCtrl = addrHit(msgAddr, `PCC_OFS_CTRL);
   assign cfgWrite = takeWrite(msgValid, msgOk, msgWrite, hitCfg);
   assign ctrlWrite = takeWrite(msgValid, msgOk, msgWrite, hitCtrl);
   assign releaseA = mayRelease(clrReq_q, aModeQ_q, classACondition);
   assign releaseB = mayRelease(clrReq_q, bModeQ_q, classBCondition);

   // ----------------------------------------------------------------
   // next values
   // ----------------------------------------------------------------
   always @* begin
      bModeQ_d = bModeQ_q;
      if (cfgWrite) begin
         bModeQ_d = msgWdata[`PCC_BIT_BMODE];
      end
   end

   always @* begin
      aModeQ_d = aModeQ_q;
      if (cfgWrite) begin
         aModeQ_d = msgWdata[`PCC_BIT_AMODE];
      end
   end

   always @* begin
      rxChk_d = rxChk_q;
      if (cfgWrite) begin
         rxChk_d = msgWdata[`PCC_BIT_RXCHK];
      end
   end

   always @* begin
      blank_d = blank_q;
      if (ctrlWrite) begin
         blank_d = msgWdata[`PCC_BIT_BLANK];
      end
   end

   always @* begin
      clrReq_d = 1'h0;
      if (ctrlWrite) begin
         clrReq_d = msgWdata[`PCC_BIT_CLRREQ];
      end
   end

   always @* begin
      discarded_d = discarded_q;
      if (msgValid) begin
         discarded_d = ~msgOk;
      end
   end

   // events assert a pin, and win over a release in the same cycle
   always @* begin
      faultA_d = faultA_q;
      if (faultAEvent) begin
         faultA_d = 1'h1;
      end else if (releaseA) begin
         faultA_d = 1'h0;
      end
   end

   always @* begin
      faultB_d = faultB_q;
      if (faultBEvent) begin
         faultB_d = 1'h1;
      end else if (releaseB) begin
         faultB_d = 1'h0;
      end
   end

   always @* begin
      rdData_d = rdData;
      if (msgValid) begin
         if (hitCfg) begin
            rdData_d = cfgWord;
         end else if (hitCtrl) begin
            rdData_d = ctrlWord;
         end else begin
            rdData_d = 16'h0000;
         end
      end
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bModeQ_q <= RST_CFG[`PCC_BIT_BMODE];
      end else begin
         bModeQ_q <= bModeQ_d;
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         aModeQ_q <= RST_CFG[`PCC_BIT_AMODE];
      end else begin
         aModeQ_q <= aModeQ_d;
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rxChk_q <= RST_CFG[`PCC_BIT_RXCHK];
      end else begin
         rxChk_q <= rxChk_d;
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         blank_q <= RST_CTRL[`PCC_BIT_BLANK];
      end else begin
         blank_q <= blank_d;
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         clrReq_q <= RST_CTRL[`PCC_BIT_CLRREQ];
      end else begin
         clrReq_q <= clrReq_d;
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         discarded_q <= 1'h0;
      end else begin
         discarded_q <= discarded_d;
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         faultA_q <= 1'h0;
      end else begin
         faultA_q <= faultA_d;
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         faultB_q <= 1'h0;
      end else begin
         faultB_q <= faultB_d;
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdData <= 16'h0000;
      end else begin
         rdData <= rdData_d;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign faultPinA_n = ~faultA_q;
   assign faultPinB_n = ~faultB_q;
   assign stickyClear = clrReq_q;
   assign rxCheckEnable = rxChk_q;
   assign blankingTimeSelect = blank_q;

   // ----------------------------------------------------------------
   // read back
   // ----------------------------------------------------------------
   assign cfgBody = {8'h00, bModeQ_q, aModeQ_q, 3'h0, rxChk_q, discarded_q, 1'h0};
   assign ctrlBody = {10'h000, clrReq_q, 1'h0, 1'h0, blank_q, discarded_q, 1'h0};
   assign cfgWord = withParity(cfgBody);
   assign ctrlWord = withParity(ctrlBody);

endmodule

// ---- verif/pcc_regs_sva.sv ----
// pcc_regs_sva: port checks of pcc_regs
// assumes bind onto pcc_regs
`timescale 1ns/100ps
module pcc_regs_sva(input wire clk,rst_n,msgValid,msgParityOk,msgWrite,
 input wire [6:0] msgAddr,input wire [15:0] msgWdata,rdData,input wire rxCheckEnable,
 blankingTimeSelect,stickyClear,faultAEvent,faultBEvent,classACondition,classBCondition,
 faultPinA_n,faultPinB_n);
default clocking @(posedge clk); endclocking
default disable iff (!rst_n);
wire ok=msgValid&&msgWrite&&(msgParityOk||!rxCheckEnable),ctl=msgAddr==7'h06;
wire bad=msgValid&&!msgParityOk&&rxCheckEnable,map=msgAddr==7'h04||ctl;
sequence s_bad_rd; bad ##1 !msgValid ##1 msgValid&&map; endsequence
a_clear_pulse: assert property(ok&&ctl&&msgWdata[5]|=>stickyClear) else $error("no clear");
a_pin_a: assert property(stickyClear&&!faultAEvent&&!classACondition|=>faultPinA_n)
 else $error("pin a held");
a_pin_b: assert property(stickyClear&&!faultBEvent&&!classBCondition|=>faultPinB_n)
 else $error("pin b held");
a_bad_refused: assert property(bad|=>$stable(rxCheckEnable)&&$stable(blankingTimeSelect))
 else $error("bad word taken");
a_discard_flag: assert property(s_bad_rd|=>rdData[1]) else $error("no discard");
a_odd_parity: assert property(msgValid&&map|=>^rdData) else $error("parity");
a_blank_sel: assert property(ok&&ctl|=>blankingTimeSelect==$past(msgWdata[2]))
 else $error("blank select");
a_reserved_zero: assert property(msgValid|=>rdData[15:8]==8'h00) else $error("reserved");
endmodule
bind pcc_regs pcc_regs_sva chk_u(.clk(clk),.rst_n(rst_n),.msgValid(msgValid),
 .msgParityOk(msgParityOk),.msgWrite(msgWrite),.msgAddr(msgAddr),.msgWdata(msgWdata),
 .rdData(rdData),.rxCheckEnable(rxCheckEnable),.blankingTimeSelect(blankingTimeSelect),
 .stickyClear(stickyClear),.faultAEvent(faultAEvent),.faultBEvent(faultBEvent),
 .classACondition(classACondition),.classBCondition(classBCondition),
 .faultPinA_n(faultPinA_n),.faultPinB_n(faultPinB_n));

// ---- verif/pcc_host.sv ----
// pcc_host: message port model of the host
// assumes one word per send
`timescale 1ns/100ps
module pcc_host(input wire clk,output reg msgValid=1'h0,msgParityOk=1'h0,msgWrite=1'h0,
 output reg [6:0] msgAddr=7'h00,output reg [15:0] msgWdata=16'h0000);
task send(input w,input [6:0] a,input [15:0] d,input ok);
@(posedge clk) {msgValid,msgWrite,msgAddr,msgWdata,msgParityOk}<={1'h1,w,a,d,ok};
@(posedge clk) {msgValid,msgAddr,msgWdata}<={1'h0,~a,~d};
endtask
endmodule

// ---- verif/pcc_regs_bench.sv ----
// pcc_regs_bench: scenario bench of pcc_regs
// assumes pcc_host feeds the message port
`timescale 1ns/100ps
`define CHK(n,e,g) begin comparisons++; if((g)!==(e)) begin num_errors++; \
$display("CHECK FAILED %s exp %h got %h",n,e,g); end end
module pcc_regs_bench;
reg clk=0,rst_n=0,faultAEvent=0,faultBEvent=0,classACondition=0,classBCondition=0;
wire msgValid,msgParityOk,msgWrite,rxCheckEnable,blankingTimeSelect,stickyClear;
wire faultPinA_n,faultPinB_n;
wire [6:0] msgAddr;
wire [15:0] msgWdata,rdData;
integer num_errors=0,comparisons=0;
always #12.5 clk=~clk;
pcc_host host_u(.clk(clk),.msgValid(msgValid),.msgParityOk(msgParityOk),.msgWrite(msgWrite),
 .msgAddr(msgAddr),.msgWdata(msgWdata));
pcc_regs dut_u(.clk(clk),.rst_n(rst_n),.msgValid(msgValid),.msgParityOk(msgParityOk),
 .msgWrite(msgWrite),.msgAddr(msgAddr),.msgWdata(msgWdata),.rdData(rdData),
 .rxCheckEnable(rxCheckEnable),.blankingTimeSelect(blankingTimeSelect),
 .stickyClear(stickyClear),.faultAEvent(faultAEvent),.faultBEvent(faultBEvent),
 .classACondition(classACondition),.classBCondition(classBCondition),
 .faultPinA_n(faultPinA_n),.faultPinB_n(faultPinB_n));
task rd(input [6:0] a,input [15:0] e);
host_u.send(1'h0,a,16'h0000,1'h1);
#1 `CHK("rdData",e,rdData)
endtask
task clr(input ca,input cb,input ea,input eb);
@(posedge clk) {faultAEvent,faultBEvent,classACondition,classBCondition}<={2'h3,ca,cb};
@(posedge clk) {faultAEvent,faultBEvent}<=2'h0;
#1 `CHK("faultPinA_n",1'h0,faultPinA_n)
`CHK("faultPinB_n",1'h0,faultPinB_n)
host_u.send(1'h1,7'h06,16'h0020,1'h1);
#1 `CHK("stickyClear",1'h1,stickyClear)
@(posedge clk) #1 `CHK("faultPinA_n",ea,faultPinA_n)
`CHK("faultPinB_n",eb,faultPinB_n)
rd(7'h06,16'h0001);
endtask
task t_par;
host_u.send(1'h1,7'h06,16'h0004,1'h0);
rd(7'h06,16'h0002);
host_u.send(1'h1,7'h06,16'h0004,1'h1);
#1 `CHK("blank",1'h1,blankingTimeSelect)
host_u.send(1'h1,7'h04,16'hFF38,1'h1);
#1 `CHK("rxCheckEnable",1'h0,rxCheckEnable)
host_u.send(1'h1,7'h06,16'h0000,1'h0);
#1 `CHK("blank",1'h0,blankingTimeSelect)
rd(7'h04,16'h0001);
rd(7'h10,16'h0000);
endtask
task print_verdict;
$display("errors %0d comparisons %0d",num_errors,comparisons);
if(num_errors==0&&comparisons>0)
$display("Simulation passed");
else
$display("Simulation failed");
$finish;
endtask
initial begin
repeat(3) @(posedge clk);
rst_n<=1'h1;
rd(7'h04,16'h00C4);
rd(7'h06,16'h0001);
`CHK("rxCheckEnable",1'h1,rxCheckEnable)
clr(1'h1,1'h1,1'h0,1'h0);
clr(1'h0,1'h1,1'h1,1'h0);
host_u.send(1'h1,7'h04,16'h0004,1'h1);
clr(1'h1,1'h1,1'h1,1'h1);
clr(1'h0,1'h0,1'h1,1'h1);
t_par;
print_verdict;
end
endmodule
